// ---- pkg/sra_pkg.sv ----
// Constants shared by both ends of the serial register link.
// Assumes a 20 MHz aclk on both ends and a host-made link clock.
`default_nettype none
package sra_pkg;
	// Command byte layout
	localparam int WEN_BIT = 7;
	localparam int DIR_BIT = 6;
	localparam logic [4:0] CMD_LAST = 5'h06;
	localparam int MODE_FIELD_MSB = 2;
	// Register select codes
	localparam logic [3:0] SEL_STATUS = 4'h0;
	localparam logic [3:0] SEL_MODE = 4'h1;
	localparam logic [3:0] SEL_MAIN_CTL = 4'h2;
	localparam logic [3:0] SEL_AUX_CTL = 4'h3;
	localparam logic [3:0] SEL_FILTER = 4'h4;
	localparam logic [3:0] SEL_MAIN_DATA = 4'h5;
	localparam logic [3:0] SEL_AUX_DATA = 4'h6;
	localparam logic [3:0] SEL_IO_CTL = 4'h7;
	localparam logic [3:0] SEL_MAIN_OFFSET = 4'h8;
	localparam logic [3:0] SEL_AUX_OFFSET = 4'h9;
	localparam logic [3:0] SEL_MAIN_GAIN = 4'hA;
	localparam logic [3:0] SEL_AUX_GAIN = 4'hB;
	localparam logic [3:0] SEL_TEST1 = 4'hC;
	localparam logic [3:0] SEL_TEST2 = 4'hD;
	localparam logic [3:0] SEL_UNDEF = 4'hE;
	localparam logic [3:0] SEL_ID = 4'hF;
	// Transfer lengths in bits
	localparam logic [4:0] BITS_WIDE = 5'h18;
	localparam logic [4:0] BITS_HALF = 5'h10;
	localparam logic [4:0] BITS_BYTE = 5'h08;
	// Flag bit positions and reset values
	localparam int FLAG_MAIN_RDY = 7;
	localparam int FLAG_AUX_RDY = 6;
	localparam int FLAG_CAL = 5;
	localparam int FLAG_NOREF = 4;
	localparam int FLAG_MAIN_ERR = 3;
	localparam int FLAG_AUX_ERR = 2;
	localparam int FLAG_LOCK = 0;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	// Arbitrary identification value
	localparam logic [7:0] ID_VALUE = 8'h3C;
	localparam logic [5:0] RESYNC_ONES = 6'h20;
	// Link clock made by the host
	localparam int ACLK_PERIOD_NS = 50;
	localparam int SCLK_PERIOD_NS = 800;
	localparam int HALF_CYCLES = SCLK_PERIOD_NS / (2 * ACLK_PERIOD_NS);
	localparam logic [3:0] HALF_LAST = 4'(HALF_CYCLES - 1);
	// Host register offsets and fields
	localparam logic [7:0] HOST_CMD_OFF = 8'h00;
	localparam logic [7:0] HOST_WDATA_OFF = 8'h04;
	localparam logic [7:0] HOST_RDATA_OFF = 8'h08;
	localparam logic [7:0] HOST_STAT_OFF = 8'h0C;
	localparam logic [7:0] HOST_RESYNC_OFF = 8'h10;
	localparam int LEN_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [4:0] reg_bits(input logic [3:0] sel);
		unique case (sel)
			SEL_MAIN_DATA, SEL_MAIN_OFFSET, SEL_MAIN_GAIN: reg_bits = BITS_WIDE;
			SEL_AUX_DATA, SEL_AUX_OFFSET, SEL_AUX_GAIN, SEL_TEST1, SEL_TEST2: reg_bits = BITS_HALF;
			default: reg_bits = BITS_BYTE;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- pkg/serial_link_if.sv ----
// Three-wire link between host and device ends.
// Assumes the bench ties both ends to this one instance.
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
	logic sclk;
	logic din;
	logic dout;
	modport host (output sclk, output din, input dout);
	modport dev (input sclk, input din, output dout);
endinterface // serial_link_if
`default_nettype wire

// ---- hw/pin_sync.sv ----
// Three-stage synchroniser for a pin from outside the aclk domain.
// Output follows only once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			level <= INIT;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// Filters a single-cycle glitch on the pin
			if (s2_reg == s3_reg) begin
				level <= s3_reg;
			end
		end
	end
endmodule // pin_sync
`default_nettype wire

// ---- hw/serial_reg_device.sv ----
// Device end: command byte decode, register transfers and status flags.
// Assumes a host driving link clock and data in; result events from user side.
// Summary of operation
// R1: Host writes command byte before any access
// R2: Back to command wait after each transfer
// R3: Reset leaves interface waiting for command
// R4: 32 ones on data in reset part
// R5: Command byte arrives MSB first
// R6: Ones at first position ignored; zero starts
// R7: Direction bit: 0 write, 1 read
// R8: Host keeps bits five, four zero
// R9: Low four bits select register
// R10: Select zero: command write, flags read
// R11: Codes 1 to 15 map remaining registers; only 1, 5, 6, 15 read data, only 1 stores writes
// R12: Flag register 8 bits, reset zero
// R13: Main ready set, cleared by read/update/mode
// R14: Aux ready set, cleared by read/update/mode
// R15: Calibration flag cleared by starting mode write
// R16: Missing reference forces main results ones
// R17: Main error on clamp or calibration fail
// R18: Aux error on clamp or calibration fail
// R19: Flag bit one reads zero
// R20: Lock flag follows PLL lock
// R21: Mode field is mode register bits 2-0
// R22: Read shifts full width MSB first
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module serial_reg_device (
	input wire logic aclk,
	input wire logic aresetn,
	serial_link_if.dev link,
	input wire logic [23:0] main_data,
	input wire logic [15:0] aux_data,
	input wire logic main_done,
	input wire logic aux_done,
	input wire logic cal_done,
	input wire logic main_clamp,
	input wire logic aux_clamp,
	input wire logic main_cal_fail,
	input wire logic aux_cal_fail,
	input wire logic main_update_soon,
	input wire logic aux_update_soon,
	input wire logic main_active,
	input wire logic ref_missing,
	input wire logic pll_locked,
	output logic [2:0] operating_mode_field,
	output logic [7:0] mode_value,
	output logic mode_write,
	output logic part_reset
);
	typedef enum logic [1:0] {WAIT_WEN, CMD_BITS, WRITE_DATA, READ_DATA} link_state_e;

	link_state_e state_reg;
	logic sclk_s;
	logic din_s;
	logic sclk_prev_reg;
	logic rise;
	logic [5:0] ones_reg;
	logic resync;
	logic [6:0] cmd_reg;
	logic [6:0] cmd_next;
	logic [3:0] sel_reg;
	logic [4:0] len_reg;
	logic [4:0] bit_cnt_reg;
	logic [23:0] shift_reg;
	logic [23:0] rd_value;
	logic [23:0] read_word;
	logic [4:0] new_len;
	logic cmd_done;
	logic last_bit;
	logic write_end;
	logic mode_commit;
	logic [7:0] mode_next;
	logic starts_op;
	logic main_read_end;
	logic aux_read_end;
	logic [7:0] flag_reg;
	logic [7:0] flag_view;

	// Link clock idles high, so its synchroniser starts high
	pin_sync #(.INIT(1'b1)) u_sclk (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(link.sclk),
		.level(sclk_s)
	);
	pin_sync #(.INIT(1'b0)) u_din (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(link.din),
		.level(din_s)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_s;
		end
	end

	assign rise = sclk_s & ~sclk_prev_reg;

	// R4: count high bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ones_reg <= 6'h00;
		end else if (rise) begin
			if (!din_s) begin
				ones_reg <= 6'h00;
			end else if (ones_reg != sra_pkg::RESYNC_ONES) begin
				ones_reg <= ones_reg + 6'h01;
			end
		end
	end

	// R4: fires once, on the 32nd high bit
	assign resync = rise & din_s & (ones_reg == sra_pkg::RESYNC_ONES - 6'h01);

	// R5: shift in MSB first
	assign cmd_next = {cmd_reg[5:0], din_s};
	assign cmd_done = rise && (state_reg == CMD_BITS) && (bit_cnt_reg == sra_pkg::CMD_LAST);
	// R9: low four bits select
	assign new_len = sra_pkg::reg_bits(cmd_next[3:0]);
	assign last_bit = (bit_cnt_reg == len_reg - 5'h01);
	assign write_end = rise && (state_reg == WRITE_DATA) && last_bit;
	assign mode_commit = write_end && (sel_reg == sra_pkg::SEL_MODE);
	assign mode_next = {shift_reg[6:0], din_s};
	// R21: field in mode bits 2-0
	assign starts_op = mode_commit && (mode_next[sra_pkg::MODE_FIELD_MSB:0] >= sra_pkg::MODE_SINGLE);
	assign main_read_end = rise && (state_reg == READ_DATA) && last_bit
		&& (sel_reg == sra_pkg::SEL_MAIN_DATA);
	assign aux_read_end = rise && (state_reg == READ_DATA) && last_bit
		&& (sel_reg == sra_pkg::SEL_AUX_DATA);

	// R3: reset lands in command wait
	always_ff @(posedge aclk) begin
		if (!aresetn || resync) begin
			state_reg <= WAIT_WEN;
			bit_cnt_reg <= 5'h00;
		end else if (rise) begin
			unique case (state_reg)
				WAIT_WEN: begin
					// R6: stay until a zero
					if (!din_s) begin
						state_reg <= CMD_BITS;
						bit_cnt_reg <= 5'h00;
					end
				end
				CMD_BITS: begin
					if (bit_cnt_reg == sra_pkg::CMD_LAST) begin
						bit_cnt_reg <= 5'h00;
						// R7: direction bit
						if (cmd_next[sra_pkg::DIR_BIT]) begin
							state_reg <= READ_DATA;
						// R10: select zero write is a new command
						end else if (cmd_next[3:0] == sra_pkg::SEL_STATUS) begin
							state_reg <= WAIT_WEN;
						end else begin
							state_reg <= WRITE_DATA;
						end
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
					end
				end
				WRITE_DATA, READ_DATA: begin
					// R2: back to command wait
					if (last_bit) begin
						state_reg <= WAIT_WEN;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || resync) begin
			cmd_reg <= 7'h00;
			sel_reg <= 4'h0;
			len_reg <= sra_pkg::BITS_BYTE;
		end else if (rise && state_reg == CMD_BITS) begin
			cmd_reg <= cmd_next;
			if (cmd_done) begin
				sel_reg <= cmd_next[3:0];
				len_reg <= new_len;
			end
		end
	end

	assign flag_view = {flag_reg[7:2], 1'b0, flag_reg[0]};

	// R11: read source per select code
	always_comb begin
		unique case (cmd_next[3:0])
			// R10: select zero reads flags
			sra_pkg::SEL_STATUS: rd_value = {16'h0000, flag_view};
			sra_pkg::SEL_MODE: rd_value = {16'h0000, mode_value};
			// R16: forced all ones without reference
			sra_pkg::SEL_MAIN_DATA: rd_value = flag_reg[sra_pkg::FLAG_NOREF] ? 24'hFFFFFF : main_data;
			sra_pkg::SEL_AUX_DATA: rd_value = {aux_data, 8'h00} >> 8;
			sra_pkg::SEL_ID: rd_value = {16'h0000, sra_pkg::ID_VALUE};
			default: rd_value = 24'h000000;
		endcase
		// R22: left-align so the MSB leaves first
		read_word = rd_value << (sra_pkg::BITS_WIDE - new_len);
	end

	// Write bits share the shifter; data out is meaningful only in reads
	always_ff @(posedge aclk) begin
		if (!aresetn || resync) begin
			shift_reg <= 24'h000000;
		end else if (cmd_done && cmd_next[sra_pkg::DIR_BIT]) begin
			shift_reg <= read_word;
		end else if (rise && state_reg == READ_DATA) begin
			// R22: next bit after each edge
			shift_reg <= {shift_reg[22:0], 1'b0};
		end else if (rise && state_reg == WRITE_DATA) begin
			shift_reg <= {shift_reg[22:0], din_s};
		end
	end

	assign link.dout = shift_reg[23];

	// R21: mode register update
	always_ff @(posedge aclk) begin
		if (!aresetn || resync) begin
			mode_value <= sra_pkg::MODE_RESET;
		end else if (mode_commit) begin
			mode_value <= mode_next;
		end
	end

	assign operating_mode_field = mode_value[sra_pkg::MODE_FIELD_MSB:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_write <= 1'b0;
			part_reset <= 1'b0;
		end else begin
			mode_write <= mode_commit;
			part_reset <= resync;
		end
	end

	// R12: flags reset to zero; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn || resync) begin
			flag_reg <= sra_pkg::FLAG_RESET;
		end else begin
			// R13: main ready
			flag_reg[sra_pkg::FLAG_MAIN_RDY] <= main_done | cal_done
				| (flag_reg[sra_pkg::FLAG_MAIN_RDY] & ~(main_read_end | main_update_soon | mode_commit));
			// R14: aux ready
			flag_reg[sra_pkg::FLAG_AUX_RDY] <= aux_done | cal_done
				| (flag_reg[sra_pkg::FLAG_AUX_RDY] & ~(aux_read_end | aux_update_soon | mode_commit));
			// R15: calibration done
			flag_reg[sra_pkg::FLAG_CAL] <= cal_done | (flag_reg[sra_pkg::FLAG_CAL] & ~starts_op);
			// R16: only while main converter runs
			flag_reg[sra_pkg::FLAG_NOREF] <= main_active & ref_missing;
			// R17: main error
			flag_reg[sra_pkg::FLAG_MAIN_ERR] <= main_clamp | main_cal_fail
				| (flag_reg[sra_pkg::FLAG_MAIN_ERR] & ~mode_commit);
			// R18: aux error
			flag_reg[sra_pkg::FLAG_AUX_ERR] <= aux_clamp | aux_cal_fail
				| (flag_reg[sra_pkg::FLAG_AUX_ERR] & ~mode_commit);
			// R19: reserved bit
			flag_reg[1] <= 1'b0;
			// R20: lock follows PLL
			flag_reg[sra_pkg::FLAG_LOCK] <= pll_locked;
		end
	end
endmodule // serial_reg_device
`default_nettype wire

// ---- hw/serial_reg_host.sv ----
// Host end: AXI4-Lite registers drive one serial transfer at a time.
// Assumes a device end on serial_link_if; this end makes the link clock.
`timescale 1ns/1ps
`default_nettype none
module serial_reg_host (
	input wire logic aclk,
	input wire logic aresetn,
	serial_link_if.host link,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	typedef enum logic [1:0] {IDLE, LOW_HALF, HIGH_HALF} eng_state_e;

	eng_state_e eng_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [7:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write;
	logic busy;
	logic start_xfer;
	logic start_resync;
	logic [7:0] cmd_reg;
	logic [4:0] len_reg;
	logic [23:0] tx_data_reg;
	logic [23:0] rx_reg;
	logic done_reg;
	logic stat_read;
	logic [31:0] tx_reg;
	logic [5:0] bit_idx_reg;
	logic [5:0] total_reg;
	logic [3:0] div_reg;
	logic dout_s;
	logic half_end;
	logic [4:0] xfer_len;

	pin_sync #(.INIT(1'b0)) u_dout (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(link.dout),
		.level(dout_s)
	);

	assign busy = (eng_reg != IDLE);
	assign awready = !aw_got_reg && !bvalid;
	assign wready = !w_got_reg && !bvalid;
	assign arready = !rvalid;
	assign do_write = aw_got_reg && w_got_reg && !bvalid;
	assign start_xfer = do_write && waddr_reg == sra_pkg::HOST_CMD_OFF && wstrb_reg[0] && !busy;
	assign start_resync = do_write && waddr_reg == sra_pkg::HOST_RESYNC_OFF && !busy;
	assign stat_read = arvalid && arready && araddr == sra_pkg::HOST_STAT_OFF;
	// Length byte left out of the write keeps the previous length
	assign xfer_len = wstrb_reg[1] ? wdata_reg[sra_pkg::LEN_LSB +: 5] : len_reg;

	// Address and data are taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid <= 1'b0;
			bresp <= sra_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_got_reg <= 1'b1;
				waddr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end
			if (do_write) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid <= 1'b1;
				// Command or resync writes while busy, and writes to offsets other than data, command and resync, are refused
				if (start_xfer || start_resync || waddr_reg == sra_pkg::HOST_WDATA_OFF) begin
					bresp <= sra_pkg::RESP_OKAY;
				end else begin
					bresp <= sra_pkg::RESP_SLVERR;
				end
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_reg <= 8'h00;
			len_reg <= 5'h00;
			tx_data_reg <= 24'h000000;
		end else if (start_xfer) begin
			cmd_reg <= wdata_reg[7:0];
			len_reg <= xfer_len;
		end else if (do_write && waddr_reg == sra_pkg::HOST_WDATA_OFF) begin
			for (int i = 0; i < 3; i++) begin
				if (wstrb_reg[i]) begin
					tx_data_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= sra_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= sra_pkg::RESP_OKAY;
			unique case (araddr)
				sra_pkg::HOST_CMD_OFF: rdata <= {19'h00000, len_reg, cmd_reg};
				sra_pkg::HOST_WDATA_OFF: rdata <= {8'h00, tx_data_reg};
				sra_pkg::HOST_RDATA_OFF: rdata <= {8'h00, rx_reg};
				sra_pkg::HOST_STAT_OFF: rdata <= {30'h00000000, done_reg, busy};
				default: begin
					rdata <= 32'h00000000;
					rresp <= sra_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	assign half_end = (div_reg == sra_pkg::HALF_LAST);

	// Link clock by division; idles high between transfers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eng_reg <= IDLE;
			link.sclk <= 1'b1;
			link.din <= 1'b1;
			div_reg <= 4'h0;
			bit_idx_reg <= 6'h00;
			total_reg <= 6'h00;
			tx_reg <= 32'h00000000;
			rx_reg <= 24'h000000;
		end else if (start_xfer || start_resync) begin
			eng_reg <= LOW_HALF;
			link.sclk <= 1'b0;
			div_reg <= 4'h0;
			bit_idx_reg <= 6'h00;
			rx_reg <= 24'h000000;
			if (start_resync) begin
				tx_reg <= 32'hFFFFFFFF;
				link.din <= 1'b1;
				total_reg <= sra_pkg::RESYNC_ONES;
			end else begin
				tx_reg <= {wdata_reg[7:0], tx_data_reg << (sra_pkg::BITS_WIDE - xfer_len)};
				link.din <= wdata_reg[7];
				total_reg <= {1'b0, sra_pkg::BITS_BYTE} + {1'b0, xfer_len};
			end
		end else if (busy) begin
			div_reg <= half_end ? 4'h0 : div_reg + 4'h1;
			if (half_end && eng_reg == LOW_HALF) begin
				// Sampled late in the low half, after the device has moved
				if (bit_idx_reg >= 6'h08) begin
					rx_reg <= {rx_reg[22:0], dout_s};
				end
				link.sclk <= 1'b1;
				eng_reg <= HIGH_HALF;
			end else if (half_end) begin
				if (bit_idx_reg == total_reg - 6'h01) begin
					eng_reg <= IDLE;
				end else begin
					link.sclk <= 1'b0;
					link.din <= tx_reg[30];
					tx_reg <= {tx_reg[30:0], 1'b0};
					bit_idx_reg <= bit_idx_reg + 6'h01;
					eng_reg <= LOW_HALF;
				end
			end
		end
	end

	// Done is sticky; a finishing transfer beats a status read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_reg <= 1'b0;
		end else if (busy && half_end && eng_reg == HIGH_HALF && bit_idx_reg == total_reg - 6'h01) begin
			done_reg <= 1'b1;
		end else if (stat_read || start_xfer || start_resync) begin
			done_reg <= 1'b0;
		end
	end
endmodule // serial_reg_host
`default_nettype wire

// ---- tb/serial_link_asserts.sv ----
// Checker for the three-wire link between the host and device ends.
// Assumes sclk and din are registered by the host in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module serial_link_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout
);
	logic sclk_last_reg;
	logic [3:0] high_run_reg;
	logic [5:0] fall_count_reg;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		sclk_last_reg <= sclk;
	end
	// Nine high cycles in a row only happen between frames
	always_ff @(posedge aclk) begin
		if (!aresetn || !sclk)
			high_run_reg <= 4'h0;
		else if (high_run_reg != 4'hF)
			high_run_reg <= high_run_reg + 4'h1;
	end
	// A fall on the closing cycle already belongs to the next frame
	always_ff @(posedge aclk) begin
		if (!aresetn)
			fall_count_reg <= 6'h00;
		else if (high_run_reg == 4'h9)
			fall_count_reg <= {5'h00, !sclk};
		else if (sclk_last_reg && !sclk)
			fall_count_reg <= fall_count_reg + 6'h01;
	end
	a_idle_after_reset: assert property ($rose(aresetn) |-> sclk && din)
		else $error("link not idle after reset");
	a_low_half: assert property ($fell(sclk) |-> (!sclk)[*8] ##1 sclk)
		else $error("sclk low half not eight cycles");
	a_high_half: assert property ($rose(sclk) |-> sclk[*8])
		else $error("sclk high half too short");
	a_din_low_hold: assert property ($fell(sclk) |=> $stable(din)[*7])
		else $error("din moved inside low half");
	a_din_at_rise: assert property ($rose(sclk) |-> $stable(din))
		else $error("din moved at sclk rise");
	a_dout_after_rise: assert property (!$stable(dout) |-> sclk && $past(sclk, 2))
		else $error("dout moved outside high half");
	a_frame_min: assert property (high_run_reg == 4'h9 && fall_count_reg != 6'h00 |-> fall_count_reg >= 6'h08)
		else $error("frame shorter than command byte");
	a_frame_max: assert property (high_run_reg == 4'h9 |-> fall_count_reg <= 6'h20)
		else $error("frame longer than 32 bits");
	c_resync_frame: cover property (high_run_reg == 4'h9 && fall_count_reg == 6'h20);
	c_byte_frame: cover property (high_run_reg == 4'h9 && fall_count_reg == 6'h08);
	c_dout_move: cover property (!$stable(dout));
endmodule // serial_link_asserts
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench joining host and device ends, driven over AXI4-Lite with a flag model.
// Assumes sra_pkg offsets and a host end that makes the link clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, mode_write, part_reset;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd, ex;
	logic [23:0] main_data = 24'h0;
	logic [15:0] aux_data = 16'h0;
	logic [8:0] ev = 9'h000;
	logic main_active = 1'b0;
	logic ref_missing = 1'b0;
	logic pll_locked = 1'b0;
	logic [2:0] op_field;
	logic [7:0] mode_value, fl, mv;
	int n_fail = 0;
	int checks = 0;
	int mw_cnt = 0;
	int pr_cnt = 0;
	int n, w;
	serial_link_if link_bus();
	serial_reg_host i_serial_reg_host (.aclk(aclk), .aresetn(aresetn), .link(link_bus),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	serial_reg_device i_serial_reg_device (.aclk(aclk), .aresetn(aresetn), .link(link_bus),
		.main_data(main_data), .aux_data(aux_data), .main_done(ev[0]), .aux_done(ev[1]),
		.cal_done(ev[2]), .main_clamp(ev[3]), .aux_clamp(ev[4]), .main_cal_fail(ev[5]),
		.aux_cal_fail(ev[6]), .main_update_soon(ev[7]), .aux_update_soon(ev[8]),
		.main_active(main_active), .ref_missing(ref_missing), .pll_locked(pll_locked),
		.operating_mode_field(op_field), .mode_value(mode_value), .mode_write(mode_write),
		.part_reset(part_reset));
	serial_link_asserts i_serial_link_asserts (.aclk(aclk), .aresetn(aresetn),
		.sclk(link_bus.sclk), .din(link_bus.din), .dout(link_bus.dout));
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		if (mode_write === 1'b1) mw_cnt++;
		if (part_reset === 1'b1) pr_cnt++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_done;
		logic [31:0] st;
		logic [1:0] r;
		st = 32'h0;
		while (st[1] !== 1'b1) axi_rd(sra_pkg::HOST_STAT_OFF, st, r);
	endtask
	task automatic xfer(input logic [7:0] c, input int len, input logic [23:0] wd,
		output logic [31:0] d);
		logic [1:0] r;
		axi_wr(sra_pkg::HOST_WDATA_OFF, {8'h00, wd}, 4'hF, r);
		axi_wr(sra_pkg::HOST_CMD_OFF, {19'h0, 5'(len), c}, 4'h3, r);
		wait_done();
		axi_rd(sra_pkg::HOST_RDATA_OFF, d, r);
	endtask
	function automatic logic [7:0] stat_exp();
		return fl | {3'h0, main_active & ref_missing, 3'h0, pll_locked};
	endfunction
	task automatic sread;
		xfer(8'h40, 8, 24'h0, rd);
		chk(32'(rd[7:0]), 32'(stat_exp()));
	endtask
	task automatic fire(input logic [8:0] v);
		@(posedge aclk);
		ev <= v;
		@(posedge aclk);
		ev <= 9'h000;
		fl[7] = (fl[7] | v[0] | v[2]) & !v[7];
		fl[6] = (fl[6] | v[1] | v[2]) & !v[8];
		fl[5] = fl[5] | v[2];
		fl[3] = fl[3] | v[3] | v[5];
		fl[2] = fl[2] | v[4] | v[6];
		repeat (4) @(posedge aclk);
	endtask
	task automatic mwr(input logic [7:0] v);
		n = mw_cnt;
		mv = v;
		xfer(8'h01, 8, {16'h0, v}, rd);
		fl = fl & 8'h33;
		if (v[2:0] >= sra_pkg::MODE_SINGLE) fl[5] = 1'b0;
		chk(32'(mode_value), 32'(v));
		chk(32'(op_field), 32'(v[2:0]));
		chk(mw_cnt - n, 1);
	endtask
	function automatic int width_of(input int s);
		if (s == 5 || s == 8 || s == 10) return 24;
		if (s == 6 || s == 9 || s == 11 || s == 12 || s == 13) return 16;
		return 8;
	endfunction
	initial begin
		repeat (90000) @(posedge aclk);
		n_fail++;
		results();
	end
	initial begin
		fl = 8'h00;
		void'($urandom(90));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		main_data <= 24'($urandom);
		aux_data <= 16'($urandom);
		sread();
		mwr(8'($urandom) & 8'h5F);
		main_active <= 1'b1;
		ref_missing <= 1'b1;
		pll_locked <= 1'b1;
		fire(9'h07F);
		sread();
		xfer(8'h45, 24, 24'h0, rd);
		chk(rd & 32'h00FF_FFFF, 32'h00FF_FFFF);
		fl[7] = 1'b0;
		sread();
		ref_missing <= 1'b0;
		fire(9'h002);
		fire(9'h100);
		fire(9'h001);
		fire(9'h080);
		sread();
		mwr(8'h01);
		sread();
		mwr(8'h02);
		sread();
		fire(9'h060);
		sread();
		fire(9'h007);
		for (int s = 1; s < 16; s++) begin
			w = width_of(s);
			ex = (s == 1) ? 32'(mv) : (s == 5) ? 32'(main_data) : 32'h0;
			if (s == 6) ex = 32'(aux_data);
			if (s == 15) ex = 32'(sra_pkg::ID_VALUE);
			xfer(8'h40 | 8'(s), w, 24'h0, rd);
			chk(rd & ((32'h1 << w) - 32'h1), ex);
		end
		fl[7:6] = 2'b00;
		sread();
		xfer(8'hFF, 16, 24'h004000, rd);
		chk(32'(rd[7:0]), 32'(stat_exp()));
		xfer(8'h00, 0, 24'h0, rd);
		sread();
		axi_wr(sra_pkg::HOST_CMD_OFF, {19'h0, 5'h08, 8'h40}, 4'h3, rsp);
		axi_wr(sra_pkg::HOST_CMD_OFF, {19'h0, 5'h08, 8'h41}, 4'h3, rsp);
		chk(32'(rsp), 32'(sra_pkg::RESP_SLVERR));
		wait_done();
		axi_rd(sra_pkg::HOST_RDATA_OFF, rd, rsp);
		chk(32'(rd[7:0]), 32'(stat_exp()));
		axi_rd(8'h14, rd, rsp);
		chk(32'(rsp), 32'(sra_pkg::RESP_SLVERR));
		n = mw_cnt;
		xfer(8'h04, 8, 24'h0000FF, rd);
		chk(mw_cnt - n, 0);
		chk(32'(mode_value), 32'(mv));
		axi_rd(sra_pkg::HOST_CMD_OFF, rd, rsp);
		chk(rd, {19'h00000, 5'h08, 8'h04});
		main_active <= 1'b0;
		pll_locked <= 1'b0;
		mwr(8'h05);
		n = pr_cnt;
		axi_wr(sra_pkg::HOST_RESYNC_OFF, 32'h0, 4'hF, rsp);
		wait_done();
		fl = 8'h00;
		chk(pr_cnt - n, 1);
		chk(32'(mode_value), 32'(sra_pkg::MODE_RESET));
		sread();
		results();
	end
endmodule // tb_top
`default_nettype wire
